// file: core/emul_capture_regs.vh
// Register offsets, field positions, reset values and timing counts.
`ifndef EMUL_CAPTURE_REGS_VH
`define EMUL_CAPTURE_REGS_VH

`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_MAP_ADDR    8'h08
`define REG_MAP_DATA    8'h0C
`define REG_LAST_LO     8'h10
`define REG_LAST_HI     8'h14

`define CTRL_BREAK_BIT  0
`define CTRL_IRQEN_BIT  1
`define CTRL_ABUF_BIT   2
`define CTRL_BANK_BIT   3
`define CTRL_RESET      4'h1

`define STAT_BREAK_BIT  0
`define STAT_IRQN_BIT   1

`define ADDR_SETUP      3'h6
`define STROBE_LEN      3'h2
`define HOLD_LEN        3'h3

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// file: core/input_sync3.v
// Three-stage input synchroniser that passes a value once stages agree.
`default_nettype none

module input_sync3 #(
  parameter WIDTH     = 1,
  parameter RESET_VAL = 0
) (
  input  wire             ref_clk,
  input  wire             sys_rst,
  input  wire [WIDTH-1:0] pinIn,
  output reg  [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;

  // Only stage2 reads stage1; the agreement test looks at stages two and
  // three, so a half-settled first stage never reaches the logic.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1  <= RESET_VAL[WIDTH-1:0];
      stage2  <= RESET_VAL[WIDTH-1:0];
      stage3  <= RESET_VAL[WIDTH-1:0];
      syncOut <= RESET_VAL[WIDTH-1:0];
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        syncOut <= stage3;
      end
    end
  end

endmodule

`default_nettype wire

// file: core/emul_break_capture.v
// Break, interrupt and last-address capture logic with an AXI4-Lite slave.
// Behaviour
// - The break line follows a control bit and reads back in status.
// - Interrupt enable set and break line low drive the interrupt low.
// - Lines 8-23 are driven only under card select and buffer enable.
// - A mapper write access produces the active-low mapper write strobe.
// - The capture flip-flop clears while the mapper write strobe is low.
// - A rising capture edge loads the synchronised address lines 8-23 as the last address.
// - A mapper write with the address buffer enabled leaves its address as the last address; without it, the pod's address.
// - The host reads either last-address register at its own bus address.
// - The captured word has line 8 at bit 0 up to line 23 at bit 15.
// - Mapper data leaves on host data bit 0, and reads return that bit.
// - Bank select high enables the first mapper RAM, low the second.
//
// Our own choices: the AXI4-Lite slave port and the address map.
`include "emul_capture_regs.vh"
`default_nettype none

module emul_break_capture (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output wire        breakRequestN,
  input  wire        breakRequestNIn,
  output reg         hostIrqRequestN,
  output reg         cardSelectN,
  output wire        addrBufferEnableN,
  output wire        podBufferDisable,
  output reg         mapWriteStrobeN,
  output wire        captureLastAddr,
  output wire [15:0] emulAddrLineOut,
  output wire        emulAddrLineOe,
  input  wire [15:0] emulAddrLineIn,
  output reg         hostDataBit0Out,
  input  wire        hostDataBit0In,
  output wire        ramEnableFirstN,
  output wire        ramEnableSecondN
);

  localparam ST_IDLE   = 2'h0;
  localparam ST_SETUP  = 2'h1;
  localparam ST_STROBE = 2'h2;
  localparam ST_HOLD   = 2'h3;
  reg  [3:0]  ctrl;
  reg  [15:0] mapAddr;
  reg  [15:0] lastAddr;
  reg         captureFf;
  reg         capturePrev;
  reg  [1:0]  state;
  reg  [2:0]  count;
  reg         opRead;
  reg         awHeld;
  reg         wHeld;
  reg  [7:0]  awAddr;
  reg  [31:0] wData;
  reg  [3:0]  wStrb;
  wire        breakLevel;
  wire [15:0] addrSync;
  wire        ramBitSync;
  wire        ramBankPick;
  wire        writeGo;
  wire        readGo;
  reg  [31:0] readWord;
  reg         readHit;
  input_sync3 #(.WIDTH(1), .RESET_VAL(1)) breakSync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .pinIn   (breakRequestNIn),
    .syncOut (breakLevel)
  );
  input_sync3 #(.WIDTH(17), .RESET_VAL(0)) busSync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .pinIn   ({hostDataBit0In, emulAddrLineIn}),
    .syncOut ({ramBitSync, addrSync})
  );
  assign breakRequestN     = ctrl[`CTRL_BREAK_BIT];
  assign addrBufferEnableN = ~ctrl[`CTRL_ABUF_BIT];
  // The pod's own buffers must float whenever this card drives the bus.
  assign podBufferDisable  = ctrl[`CTRL_ABUF_BIT];
  assign ramBankPick       = ctrl[`CTRL_BANK_BIT];
  assign emulAddrLineOe    = ~cardSelectN & ~addrBufferEnableN;
  // Bit i of the word is address line 8+i.
  assign emulAddrLineOut   = mapAddr;
  assign ramEnableFirstN   = cardSelectN | ~ramBankPick;
  assign ramEnableSecondN  = cardSelectN | ramBankPick;
  assign captureLastAddr   = captureFf;
  assign s_axi_awready = ~awHeld;
  assign s_axi_wready  = ~wHeld;
  assign writeGo = awHeld & wHeld & ~s_axi_bvalid & (state == ST_IDLE);
  // Writes win when both directions are ready, so reads wait while a write is held.
  assign s_axi_arready = (state == ST_IDLE) & ~s_axi_rvalid &
                         ~(awHeld & wHeld);
  assign readGo = s_axi_arvalid & s_axi_arready;
  always @* begin
    readHit  = 1'b1;
    readWord = 32'h0000_0000;
    case (s_axi_araddr)
      `REG_CTRL:     readWord = {28'h000_0000, ctrl};
      `REG_STATUS:   readWord = {30'h0, hostIrqRequestN,
                                 breakLevel};
      `REG_MAP_ADDR: readWord = {16'h0000, mapAddr};
      `REG_LAST_LO:  readWord = {24'h00_0000, lastAddr[7:0]};
      `REG_LAST_HI:  readWord = {24'h00_0000, lastAddr[15:8]};
      default:       readHit  = 1'b0;
    endcase
  end
  // Interrupt follows the line's real level, so an outside pull also counts.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hostIrqRequestN <= 1'b1;
    end else begin
      hostIrqRequestN <= ~(ctrl[`CTRL_IRQEN_BIT] & ~breakLevel);
    end
  end
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      captureFf <= 1'b1;
    end else if (!mapWriteStrobeN) begin
      captureFf <= 1'b0;
    end else begin
      captureFf <= 1'b1;
    end
  end
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      capturePrev <= 1'b1;
      lastAddr    <= 16'h0000;
    end else begin
      capturePrev <= captureFf;
      // Nothing else writes lastAddr, so reads leave it untouched.
      if (captureFf && !capturePrev) begin
        lastAddr <= addrSync;
      end
    end
  end
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awAddr <= 8'h00;
      wData  <= 32'h0000_0000;
      wStrb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && !awHeld) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (writeGo) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && !wHeld) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (writeGo) begin
        wHeld <= 1'b0;
      end
    end
  end
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl            <= `CTRL_RESET;
      mapAddr         <= 16'h0000;
      state           <= ST_IDLE;
      count           <= 3'h0;
      opRead          <= 1'b0;
      cardSelectN     <= 1'b1;
      mapWriteStrobeN <= 1'b1;
      hostDataBit0Out <= 1'b0;
      s_axi_bvalid    <= 1'b0;
      s_axi_bresp     <= `RESP_OKAY;
      s_axi_rvalid    <= 1'b0;
      s_axi_rresp     <= `RESP_OKAY;
      s_axi_rdata     <= 32'h0000_0000;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          count <= 3'h0;
          if (writeGo) begin
            s_axi_bresp <= `RESP_OKAY;
            case (awAddr)
              `REG_CTRL: begin
                if (wStrb[0]) begin
                  ctrl <= wData[3:0];
                end
                s_axi_bvalid <= 1'b1;
              end
              `REG_MAP_ADDR: begin
                if (wStrb[0]) begin
                  mapAddr[7:0] <= wData[7:0];
                end
                if (wStrb[1]) begin
                  mapAddr[15:8] <= wData[15:8];
                end
                s_axi_bvalid <= 1'b1;
              end
              `REG_MAP_DATA: begin
                hostDataBit0Out <= wData[0];
                opRead          <= 1'b0;
                cardSelectN     <= 1'b0;
                state           <= ST_SETUP;
              end
              `REG_STATUS, `REG_LAST_LO, `REG_LAST_HI: begin
                s_axi_bvalid <= 1'b1;
              end
              default: begin
                s_axi_bresp  <= `RESP_SLVERR;
                s_axi_bvalid <= 1'b1;
              end
            endcase
          end else if (readGo) begin
            if (s_axi_araddr == `REG_MAP_DATA) begin
              opRead      <= 1'b1;
              cardSelectN <= 1'b0;
              state       <= ST_SETUP;
            end else begin
              s_axi_rdata  <= readWord;
              s_axi_rresp  <= readHit ? `RESP_OKAY : `RESP_SLVERR;
              s_axi_rvalid <= 1'b1;
            end
          end
        end
        // Setup outlasts the input synchroniser, so the bus value seen
        // at capture is the settled one.
        ST_SETUP: begin
          if (count == `ADDR_SETUP - 3'h1) begin
            count <= 3'h0;
            if (opRead) begin
              state <= ST_HOLD;
            end else begin
              mapWriteStrobeN <= 1'b0;
              state           <= ST_STROBE;
            end
          end else begin
            count <= count + 3'h1;
          end
        end
        ST_STROBE: begin
          if (count == `STROBE_LEN - 3'h1) begin
            count           <= 3'h0;
            mapWriteStrobeN <= 1'b1;
            state           <= ST_HOLD;
          end else begin
            count <= count + 3'h1;
          end
        end
        ST_HOLD: begin
          if (count == `HOLD_LEN - 3'h1) begin
            count       <= 3'h0;
            cardSelectN <= 1'b1;
            state       <= ST_IDLE;
            if (opRead) begin
              s_axi_rdata  <= {31'h0, ramBitSync};
              s_axi_rresp  <= `RESP_OKAY;
              s_axi_rvalid <= 1'b1;
            end else begin
              s_axi_bresp  <= `RESP_OKAY;
              s_axi_bvalid <= 1'b1;
            end
          end else begin
            count <= count + 3'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

`default_nettype wire

// file: test/emul_break_capture_assertions.sv
// Checker for the strobe, capture, buffer and interrupt outputs.
`default_nettype none
module emul_break_capture_assertions (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic cardSelectN,
  input wire logic addrBufferEnableN,
  input wire logic podBufferDisable,
  input wire logic emulAddrLineOe,
  input wire logic ramEnableFirstN,
  input wire logic ramEnableSecondN,
  input wire logic mapWriteStrobeN,
  input wire logic captureLastAddr,
  input wire logic breakRequestNIn,
  input wire logic hostIrqRequestN
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence strobePulse;
    $fell(mapWriteStrobeN) ##1 !mapWriteStrobeN ##1 mapWriteStrobeN;
  endsequence
  buf_pair_a: assert property (
    addrBufferEnableN != podBufferDisable)
    else $error("buffer enables disagree");
  addr_drive_a: assert property (emulAddrLineOe ==
    (!cardSelectN && !addrBufferEnableN)) else $error("address drive wrong");
  bank_pick_a: assert property (cardSelectN ?
    (ramEnableFirstN && ramEnableSecondN) :
    (ramEnableFirstN != ramEnableSecondN)) else $error("bank enable wrong");
  strobe_sel_a: assert property (
    !mapWriteStrobeN |-> !cardSelectN) else $error("strobe outside access");
  strobe_len_a: assert property ($fell(mapWriteStrobeN) |=>
    !mapWriteStrobeN ##1 mapWriteStrobeN) else $error("strobe length wrong");
  capture_clr_a: assert property ($fell(mapWriteStrobeN) |=>
    !captureLastAddr) else $error("capture not cleared");
  capture_cause_a: assert property ($fell(captureLastAddr) |->
    !$past(mapWriteStrobeN)) else $error("capture cleared without strobe");
  capture_set_a: assert property (strobePulse |=> captureLastAddr)
    else $error("capture did not rise");
  irq_quiet_a: assert property (
    breakRequestNIn[*8] |-> hostIrqRequestN)
    else $error("interrupt without break");
endmodule
bind emul_break_capture emul_break_capture_assertions chk (.*);
`default_nettype wire

// file: test/emul_pod_model.sv
// Pod side model: break pull-up, pod address drive and two mapper RAMs.
`default_nettype none
module emul_pod_model #(
  parameter logic [15:0] POD_ADDR = 16'hA5C3
) (
  input  wire logic        ref_clk,
  input  wire logic        breakRequestN,
  output logic             breakRequestNIn,
  input  wire logic [15:0] emulAddrLineOut,
  input  wire logic        emulAddrLineOe,
  output logic      [15:0] emulAddrLineIn,
  input  wire logic        mapWriteStrobeN,
  input  wire logic        ramEnableFirstN,
  input  wire logic        ramEnableSecondN,
  input  wire logic        hostDataBit0Out,
  output logic             hostDataBit0In
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ramFirst [65536];
  logic ramSecond [65536];
  logic toggle = 1'b0;
  always @(posedge ref_clk) toggle <= ~toggle;
  // The break line has a pull-up, so the card's own drive reads back.
  assign breakRequestNIn = breakRequestN;
  // The pod drives its own address only while the card leaves the bus.
  assign emulAddrLineIn = emulAddrLineOe ? emulAddrLineOut :
    POD_ADDR;
  always @(posedge ref_clk) begin
    if (!mapWriteStrobeN && !ramEnableFirstN)
      ramFirst[emulAddrLineIn] <= hostDataBit0Out;
    if (!mapWriteStrobeN && !ramEnableSecondN)
      ramSecond[emulAddrLineIn] <= hostDataBit0Out;
  end
  // An unselected RAM output floats, shown here as a changing level.
  assign hostDataBit0In = !ramEnableFirstN ?
    ramFirst[emulAddrLineIn] : !ramEnableSecondN ?
    ramSecond[emulAddrLineIn] : toggle;
endmodule
`default_nettype wire

// file: test/emul_break_capture_tb.sv
// Self-checking bench for the break and last-address capture block.
`include "emul_capture_regs.vh"
`default_nettype none
module emul_break_capture_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, breakRequestN, breakRequestNIn, hostIrqRequestN;
  logic cardSelectN, addrBufferEnableN, podBufferDisable, mapWriteStrobeN;
  logic captureLastAddr, emulAddrLineOe, hostDataBit0Out, hostDataBit0In;
  logic ramEnableFirstN, ramEnableSecondN;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] emulAddrLineOut, emulAddrLineIn;
  int mismatches = 0;
  int checks = 0;
  always #4 ref_clk = ~ref_clk;
  emul_break_capture DUT (.*);
  emul_pod_model pod (.*);
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Each wait is bounded so a stuck handshake ends the run.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
    if (n == 40) mismatches++;
    if (n == 40) test_done();
  endtask
  task automatic rdreg(input logic [7:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
    if (n == 40) mismatches++;
    if (n == 40) test_done();
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rdreg(a);
    cmp(rd, e);
  endtask
  task automatic t_reset();
    rc(`REG_CTRL, 32'h1);
    cmp({31'h0, breakRequestN}, 32'h1);
    rc(`REG_LAST_LO, 32'h0);
    rdreg(8'h40);
    cmp({30'h0, rsp}, {30'h0, `RESP_SLVERR});
    wr(`REG_LAST_LO, 32'hFF);
    cmp({30'h0, rsp}, {30'h0, `RESP_OKAY});
    wr(8'h40, 32'hFF);
    cmp({30'h0, rsp}, {30'h0, `RESP_SLVERR});
    rc(`REG_LAST_LO, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_break();
    logic [3:0] c [4] = '{4'h0, 4'h2, 4'h3, 4'h1};
    logic [1:0] s [4] = '{2'h2, 2'h0, 2'h3, 2'h3};
    for (int i = 0; i < 4; i++) begin
      wr(`REG_CTRL, {28'h0, c[i]});
      cmp({31'h0, breakRequestN}, {31'h0, c[i][0]});
      repeat (8) @(posedge ref_clk);
      rc(`REG_STATUS, {30'h0, s[i]});
      cmp({31'h0, hostIrqRequestN}, {31'h0, s[i][1]});
    end
    $display("break test done");
  endtask
  task automatic t_capture();
    logic [15:0] p [4] = '{16'h0001, 16'h8000, 16'h1248, 16'hEDB7};
    wr(`REG_CTRL, 32'h5);
    for (int i = 0; i < 4; i++) begin
      wr(`REG_MAP_ADDR, {16'h0, p[i]});
      cmp({16'h0, emulAddrLineOut}, {16'h0, p[i]});
      wr(`REG_MAP_DATA, {31'h0, i[0]});
      rc(`REG_LAST_LO, {24'h0, p[i][7:0]});
      rc(`REG_LAST_HI, {24'h0, p[i][15:8]});
      rc(`REG_MAP_DATA, {31'h0, i[0]});
      rc(`REG_LAST_LO, {24'h0, p[i][7:0]});
    end
    // The second RAM holds a one at the last address, so a zero written
    // through the first bank shows that the banks are kept apart.
    wr(`REG_CTRL, 32'hD);
    wr(`REG_MAP_DATA, 32'h0);
    cmp({31'h0, pod.ramFirst[16'hEDB7]}, 32'h0);
    rc(`REG_MAP_DATA, 32'h0);
    wr(`REG_CTRL, 32'h5);
    rc(`REG_MAP_DATA, 32'h1);
    wr(`REG_CTRL, 32'h1);
    wr(`REG_MAP_DATA, 32'h0);
    rc(`REG_LAST_HI, 32'hA5);
    rc(`REG_LAST_LO, 32'hC3);
    $display("capture test done");
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_break();
    t_capture();
    test_done();
  end
endmodule
`default_nettype wire
